// >>> hdl/pwl_regs.svh
`ifndef PWL_REGS_SVH
`define PWL_REGS_SVH

// Register offsets, byte addresses on the plain port
`define PWL_ADDR_FUNC0     8'h00
`define PWL_ADDR_FUNC1     8'h04
`define PWL_ADDR_HOLD      8'h08
`define PWL_ADDR_DISP      8'h0c
`define PWL_ADDR_SRC       8'h10
`define PWL_ADDR_DUTY0     8'h14
`define PWL_ADDR_DUTY1     8'h18
`define PWL_ADDR_STATUS    8'h1c

// Reset values
`define PWL_FUNC0_RST      2'h1
`define PWL_FUNC1_RST      2'h0
`define PWL_HOLD_RST       8'hff
`define PWL_DISP_RST       8'h28
`define PWL_SRC_RST        16'h0000
`define PWL_DUTY_RST       10'h000

// Status bit positions
`define PWL_ST_PASS0       0
`define PWL_ST_PASS1       1
`define PWL_ST_HOLD        2
`define PWL_ST_LIVE        3

// Timing
`define PWL_CLK_NS         40
`define PWL_PERIOD_NS      64000
`define PWL_TICK_MS        100
`define PWL_NS_PER_MS      1000000
`define PWL_DISP_FOREVER   8'hff

// Duty scaling
`define PWL_DUTY_FULL      10'h3ff
`define PWL_DUTY_MUL       5'h19
`define PWL_DUTY_SH        4
`define PWL_STR_STEPS      11'h1bd
`define PWL_STR_BASE       11'h06b
`define PWL_STR_MIN        11'h005
`define PWL_STR_DB_MUL     8'hf2
`define PWL_STR_DB_SH      5
`define PWL_STR_LOW_SH     2
`define PWL_STR_MUL        7'h73
`define PWL_STR_SH         5

`endif

// >>> hdl/pwl_pkg.sv
package pwl_pkg;
  // Function select of a pulse output
  typedef enum logic [1:0] {PWL_FN_OFF, PWL_FN_STRENGTH, PWL_FN_DUTY} pwl_fn_e;
  // Compare threshold handed to a channel
  typedef struct packed {
    logic        full;
    logic [10:0] thresh;
  } pwl_cmp_s;
endpackage

// >>> hdl/pwl_duty_if.sv
`timescale 1ns/1ps
interface pwl_duty_if;
  import pwl_pkg::*;
  pwl_cmp_s cmp;
  logic     pwm;
  modport ctl  (output cmp, input pwm);
  modport chan (input cmp, output pwm);
endinterface

// >>> hdl/pwl_pwm_chan.sv
`timescale 1ns/1ps
module pwl_pwm_chan
  import pwl_pkg::*;
(
  input  wire logic        ref_clk_in,  // System clock
  input  wire logic        rst_in,      // Sync reset, high
  input  wire logic [10:0] period_in,   // Free-running period count
  pwl_duty_if.chan         dif          // Threshold in, pulse out
);
  logic pwm_r;
  logic pwm_nxt;

  // High while count below threshold, or always at full scale
  always_comb begin
    pwm_nxt = dif.cmp.full | (period_in < dif.cmp.thresh);
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= pwm_nxt;
    end
  end

  assign dif.pwm = pwm_r;
endmodule

// >>> hdl/pwl_top.sv
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "pwl_regs.svh"
module pwl_top
  import pwl_pkg::*;
#(
  parameter int TICK_CYCLES = (`PWL_TICK_MS * `PWL_NS_PER_MS) / `PWL_CLK_NS
)(
  input  wire logic              ref_clk_in,         // System clock, 25 MHz
  input  wire logic              rst_in,             // Sync reset, high
  input  wire logic [7:0]        reg_addr_in,        // Register byte address
  input  wire logic [15:0]       reg_wdata_in,       // Write data
  input  wire logic              reg_wr_in,          // Write strobe
  input  wire logic              reg_rd_in,          // Read strobe
  output logic [15:0]            reg_rdata_out,      // Read data, next cycle
  input  wire logic              rx_pkt_in,          // Any radio packet received
  input  wire logic signed [7:0] rx_margin_in,       // Packet dB above sensitivity
  input  wire logic              io_pkt_in,          // Valid I/O sample packet
  input  wire logic [15:0]       io_src_addr_in,     // Sender of the I/O packet
  input  wire logic              analog_in_0_vld_in, // Packet holds analog 0
  input  wire logic [9:0]        analog_in_0_in,     // Remote analog 0 sample
  input  wire logic              analog_in_1_vld_in, // Packet holds analog 1
  input  wire logic [9:0]        analog_in_1_in,     // Remote analog 1 sample
  output logic                   pulse_out_0_out,    // Pulse output 0
  output logic                   pulse_out_1_out     // Pulse output 1
);
  // One output period in clocks, and width of the 100 ms prescaler
  localparam int PERIOD_CYCLES = `PWL_PERIOD_NS / `PWL_CLK_NS;
  localparam int TICK_W        = $clog2(TICK_CYCLES + 1);

  // Strength level out of 445 steps from packet margin
  function automatic logic [10:0] strength_steps(input logic signed [7:0] m);
    logic signed [15:0] lo;
    logic [15:0]        hi;
    lo = 16'($signed(`PWL_STR_BASE)) + (16'(m) <<< `PWL_STR_LOW_SH);
    hi = 16'($unsigned(m)) * 16'(`PWL_STR_DB_MUL);
    hi = 16'(`PWL_STR_BASE) + (hi >> `PWL_STR_DB_SH);
    if (m <= 0) begin
      strength_steps = (lo < 16'($signed(`PWL_STR_MIN))) ? `PWL_STR_MIN : lo[10:0];
    end else if (hi >= 16'(`PWL_STR_STEPS)) begin
      strength_steps = `PWL_STR_STEPS;
    end else begin
      strength_steps = hi[10:0];
    end
  endfunction

  // Compare threshold in clock cycles for one output
  function automatic pwl_cmp_s to_cmp(input pwl_fn_e fn, input logic [9:0] lvl,
                                      input logic [10:0] steps);
    logic [17:0] prod;
    to_cmp = '{full: 1'b0, thresh: 11'h000};
    prod   = 18'h0_0000;
    unique case (fn)
      PWL_FN_OFF: begin
        to_cmp.thresh = 11'h000;
      end
      PWL_FN_STRENGTH: begin
        prod = 18'(steps) * 18'(`PWL_STR_MUL);
        to_cmp.full   = (steps >= `PWL_STR_STEPS);
        to_cmp.thresh = 11'(prod >> `PWL_STR_SH);
      end
      PWL_FN_DUTY: begin
        prod = 18'(lvl) * 18'(`PWL_DUTY_MUL);
        to_cmp.full   = (lvl == `PWL_DUTY_FULL);
        to_cmp.thresh = 11'(prod >> `PWL_DUTY_SH);
      end
      default: begin
        to_cmp.thresh = 11'h000;
      end
    endcase
  endfunction

  // Register file state
  pwl_fn_e     func0_r, func0_nxt;
  pwl_fn_e     func1_r, func1_nxt;
  logic [7:0]  hold_r, hold_nxt;
  logic [7:0]  disp_r, disp_nxt;
  logic [15:0] src_r, src_nxt;
  logic [9:0]  duty0_r, duty0_nxt;
  logic [9:0]  duty1_r, duty1_nxt;
  logic [1:0]  pass_r, pass_nxt;
  logic [15:0] rdata_r, rdata_nxt;

  // Timer state
  logic [TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
  logic              tick;
  logic [7:0]        hold_cnt_r, hold_cnt_nxt;
  logic              hold_run_r, hold_run_nxt;
  logic              hold_expire;
  logic [7:0]        disp_cnt_r, disp_cnt_nxt;
  logic              live_r, live_nxt;
  logic [10:0]       steps_r, steps_nxt;
  logic [10:0]       period_r, period_nxt;

  // Line passing qualifiers
  logic       io_match;
  logic [1:0] pass_hit;
  logic       pass_start;

  // Samples count only from the set source and only in duty mode
  assign io_match    = io_pkt_in && (io_src_addr_in == src_r);
  assign pass_hit[0] = io_match && analog_in_0_vld_in && (func0_r == PWL_FN_DUTY);
  assign pass_hit[1] = io_match && analog_in_1_vld_in && (func1_r == PWL_FN_DUTY);
  assign pass_start  = (pass_hit[0] && (analog_in_0_in != 10'h000)) ||
                       (pass_hit[1] && (analog_in_1_in != 10'h000));

  // Register writes, line passing and reads
  always_comb begin
    func0_nxt = func0_r;
    func1_nxt = func1_r;
    hold_nxt  = hold_r;
    disp_nxt  = disp_r;
    src_nxt   = src_r;
    duty0_nxt = duty0_r;
    duty1_nxt = duty1_r;
    pass_nxt  = pass_r;
    rdata_nxt = 16'h0000;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `PWL_ADDR_FUNC0: begin
          if (reg_wdata_in[1:0] <= 2'(PWL_FN_DUTY)) begin
            func0_nxt = pwl_fn_e'(reg_wdata_in[1:0]);
          end
        end
        `PWL_ADDR_FUNC1: begin
          if (reg_wdata_in[1:0] <= 2'(PWL_FN_DUTY)) begin
            func1_nxt = pwl_fn_e'(reg_wdata_in[1:0]);
          end
        end
        `PWL_ADDR_HOLD: begin
          hold_nxt = reg_wdata_in[7:0];
        end
        `PWL_ADDR_DISP: begin
          disp_nxt = reg_wdata_in[7:0];
        end
        `PWL_ADDR_SRC: begin
          src_nxt = reg_wdata_in;
        end
        `PWL_ADDR_DUTY0: begin
          duty0_nxt = reg_wdata_in[9:0];
          pass_nxt[0] = 1'b0;
        end
        `PWL_ADDR_DUTY1: begin
          duty1_nxt = reg_wdata_in[9:0];
          pass_nxt[1] = 1'b0;
        end
        default: begin
          src_nxt = src_r;
        end
      endcase
    end
    // Hold expiry zeroes only levels set by line passing
    if (hold_expire) begin
      if (pass_r[0]) begin
        duty0_nxt = 10'h000;
      end
      if (pass_r[1]) begin
        duty1_nxt = 10'h000;
      end
      pass_nxt = 2'b00;
    end
    // Passed samples win over a write or expiry in the same cycle
    if (pass_hit[0]) begin
      duty0_nxt   = analog_in_0_in;
      pass_nxt[0] = (analog_in_0_in != 10'h000);
    end
    if (pass_hit[1]) begin
      duty1_nxt   = analog_in_1_in;
      pass_nxt[1] = (analog_in_1_in != 10'h000);
    end
    // Read data stays zero unless a read strobe was taken
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `PWL_ADDR_FUNC0:  rdata_nxt = {14'h0000, 2'(func0_r)};
        `PWL_ADDR_FUNC1:  rdata_nxt = {14'h0000, 2'(func1_r)};
        `PWL_ADDR_HOLD:   rdata_nxt = {8'h00, hold_r};
        `PWL_ADDR_DISP:   rdata_nxt = {8'h00, disp_r};
        `PWL_ADDR_SRC:    rdata_nxt = src_r;
        `PWL_ADDR_DUTY0:  rdata_nxt = {6'h00, duty0_r};
        `PWL_ADDR_DUTY1:  rdata_nxt = {6'h00, duty1_r};
        `PWL_ADDR_STATUS: begin
          rdata_nxt[`PWL_ST_PASS0] = pass_r[0];
          rdata_nxt[`PWL_ST_PASS1] = pass_r[1];
          rdata_nxt[`PWL_ST_HOLD]  = hold_run_r;
          rdata_nxt[`PWL_ST_LIVE]  = live_r;
        end
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      func0_r <= pwl_fn_e'(`PWL_FUNC0_RST);
      func1_r <= pwl_fn_e'(`PWL_FUNC1_RST);
      hold_r  <= `PWL_HOLD_RST;
      disp_r  <= `PWL_DISP_RST;
      src_r   <= `PWL_SRC_RST;
      duty0_r <= `PWL_DUTY_RST;
      duty1_r <= `PWL_DUTY_RST;
      pass_r  <= 2'b00;
      rdata_r <= 16'h0000;
    end else begin
      func0_r <= func0_nxt;
      func1_r <= func1_nxt;
      hold_r  <= hold_nxt;
      disp_r  <= disp_nxt;
      src_r   <= src_nxt;
      duty0_r <= duty0_nxt;
      duty1_r <= duty1_nxt;
      pass_r  <= pass_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

  // Tick, hold timer, display timer and period counter
  always_comb begin
    tick         = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + TICK_W'(1);
    period_nxt   = (period_r == 11'(PERIOD_CYCLES - 1)) ? 11'h000
                                                        : period_r + 11'h001;
    hold_cnt_nxt = hold_cnt_r;
    hold_run_nxt = hold_run_r;
    hold_expire  = 1'b0;
    if (hold_run_r && tick) begin
      if (hold_cnt_r <= 8'h01) begin
        hold_expire  = 1'b1;
        hold_run_nxt = 1'b0;
      end else begin
        hold_cnt_nxt = hold_cnt_r - 8'h01;
      end
    end
    // New pass, or a matching I/O packet while the timer runs, reloads the timer
    // Reload beats a same-cycle expiry so a late packet keeps the level
    if ((pass_start || (io_match && hold_run_r)) && (hold_r != 8'h00)) begin
      hold_cnt_nxt = hold_r;
      hold_run_nxt = 1'b1;
      hold_expire  = 1'b0;
    end
    // Display timer; a new packet reloads it and wins over expiry
    disp_cnt_nxt = disp_cnt_r;
    live_nxt     = live_r;
    steps_nxt    = steps_r;
    if (live_r && tick && (disp_r != `PWL_DISP_FOREVER)) begin
      if (disp_cnt_r <= 8'h01) begin
        live_nxt = 1'b0;
      end else begin
        disp_cnt_nxt = disp_cnt_r - 8'h01;
      end
    end
    if (rx_pkt_in) begin
      steps_nxt    = strength_steps(rx_margin_in);
      disp_cnt_nxt = disp_r;
      live_nxt     = (disp_r != 8'h00);
    end
  end

  // Timer and period counter flops
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tick_cnt_r <= '0;
      period_r   <= 11'h000;
      hold_cnt_r <= 8'h00;
      hold_run_r <= 1'b0;
      disp_cnt_r <= 8'h00;
      live_r     <= 1'b0;
      steps_r    <= 11'h000;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      period_r   <= period_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      hold_run_r <= hold_run_nxt;
      disp_cnt_r <= disp_cnt_nxt;
      live_r     <= live_nxt;
      steps_r    <= steps_nxt;
    end
  end

  // Two compare channels
  pwl_duty_if dif [2] ();
  logic [1:0] pulse;

  // Strength threshold drops to zero once the display is not live
  assign dif[0].cmp = to_cmp(func0_r, duty0_r, live_r ? steps_r : 11'h000);
  assign dif[1].cmp = to_cmp(func1_r, duty1_r, live_r ? steps_r : 11'h000);

  // Both channels share one period count, so their edges stay aligned
  for (genvar i = 0; i < 2; i++) begin : g_chan
    pwl_pwm_chan u_chan (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .period_in  (period_r),
      .dif        (dif[i])
    );
    assign pulse[i] = dif[i].pwm;
  end

  assign pulse_out_0_out = pulse[0];
  assign pulse_out_1_out = pulse[1];
endmodule

// >>> testbench/pwl_far_model.sv
`timescale 1ns/1ps
module pwl_far_model (
  input  wire logic        ref_clk_in,      // Clock
  input  wire logic        rst_in,          // Reset
  input  wire logic        pulse_out_0_out, // Pulse 0 seen
  input  wire logic        pulse_out_1_out, // Pulse 1 seen
  output logic      [10:0] meas_0_out,      // High cycles, pulse 0
  output logic      [10:0] meas_1_out,      // High cycles, pulse 1
  output logic             meas_vld_out     // Window done
);
  logic [10:0] w_r;
  logic [10:0] h0_r;
  logic [10:0] h1_r;
  // Filter sums high time over each 64 us window of 1600 cycles
  always_ff @(posedge ref_clk_in) begin
    meas_vld_out <= 1'b0;
    if (rst_in || w_r == 11'd1599) begin
      meas_vld_out <= !rst_in;
      meas_0_out <= h0_r + {10'h0, pulse_out_0_out};
      meas_1_out <= h1_r + {10'h0, pulse_out_1_out};
      w_r <= 11'h0;
      h0_r <= 11'h0;
      h1_r <= 11'h0;
    end else begin
      w_r <= w_r + 11'h1;
      h0_r <= h0_r + {10'h0, pulse_out_0_out};
      h1_r <= h1_r + {10'h0, pulse_out_1_out};
    end
  end
endmodule

// >>> testbench/pwl_top_asserts.sv
`timescale 1ns/1ps
module pwl_top_asserts (
  input wire logic        ref_clk_in,      // Clock
  input wire logic        rst_in,          // Reset
  input wire logic [7:0]  reg_addr_in,     // Address
  input wire logic [15:0] reg_wdata_in,    // Write data
  input wire logic        reg_wr_in,       // Write strobe
  input wire logic        reg_rd_in,       // Read strobe
  input wire logic [15:0] reg_rdata_out,   // Read data
  input wire logic        rx_pkt_in,       // Radio packet
  input wire logic        io_pkt_in,       // I/O packet
  input wire logic        pulse_out_0_out, // Pulse 0
  input wire logic        pulse_out_1_out  // Pulse 1
);
  logic [1:0]  f0_r, f0_nxt, f1_r, f1_nxt;
  logic        rx_r, rx_nxt, io_r, io_nxt, p_r;
  logic [11:0] q_r, q_nxt, g_r, g_nxt;
  logic        ok_w;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Mirror of selects, packet history, quiet time and rise gap
  always_comb begin
    ok_w = reg_wr_in && reg_wdata_in[1:0] != 2'h3;
    f0_nxt = (ok_w && reg_addr_in == 8'h00) ? reg_wdata_in[1:0] : f0_r;
    f1_nxt = (ok_w && reg_addr_in == 8'h04) ? reg_wdata_in[1:0] : f1_r;
    rx_nxt = rx_r | rx_pkt_in;
    io_nxt = io_r | io_pkt_in;
    q_nxt = (reg_wr_in | rx_pkt_in | io_pkt_in) ? 12'h0 : q_r + {11'h0, q_r != 12'hfff};
    g_nxt = (pulse_out_0_out & !p_r) ? 12'h0 : g_r + {11'h0, g_r != 12'hfff};
  end
  // Helper registers
  always_ff @(posedge ref_clk_in) begin
    f0_r <= rst_in ? 2'h1 : f0_nxt;
    f1_r <= rst_in ? 2'h0 : f1_nxt;
    rx_r <= !rst_in & rx_nxt;
    io_r <= !rst_in & io_nxt;
    q_r <= rst_in ? 12'h0 : q_nxt;
    g_r <= rst_in ? 12'hfff : g_nxt;
    p_r <= pulse_out_0_out;
  end
  sequence s_rd(logic [7:0] a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  a_off_low0: assert property ((f0_r == 2'h0) [*4] |-> !pulse_out_0_out)
    else $error("pulse 0 high while off");
  a_off_low1: assert property ((f1_r == 2'h0) [*4] |-> !pulse_out_1_out)
    else $error("pulse 1 high while off");
  a_nopkt_low: assert property ((!rx_r && f0_r == 2'h1) [*4] |-> !pulse_out_0_out)
    else $error("strength high before first packet");
  a_period_len: assert property ($rose(pulse_out_0_out) && q_r > 12'd3300
    && g_r < 12'd2000 |-> g_r == 12'd1599)
    else $error("pulse period not 1600 cycles");
  a_func0_rb: assert property (s_rd(8'h00) |=> reg_rdata_out == {14'h0, f0_r})
    else $error("function 0 readback wrong");
  a_func1_rb: assert property (s_rd(8'h04) |=> reg_rdata_out == {14'h0, f1_r})
    else $error("function 1 readback wrong");
  a_pass_none: assert property (s_rd(8'h1c) ##0 !io_r |=> reg_rdata_out[2:0] == 3'h0)
    else $error("passing flagged without packet");
  a_live_none: assert property (s_rd(8'h1c) ##0 !rx_r |=> !reg_rdata_out[3])
    else $error("display live without packet");
endmodule
bind pwl_top pwl_top_asserts u_chk (.ref_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .rx_pkt_in, .io_pkt_in, .pulse_out_0_out,
  .pulse_out_1_out);

// >>> testbench/pwl_top_tb.sv
`timescale 1ns/1ps
module pwl_top_tb;
  logic              ref_clk, rst, wr, rd, rx, io, v0, v1, rd_d, mv, arm, p0, p1;
  logic       [7:0]  addr;
  logic       [15:0] wd, rdat, src, sa;
  logic signed [7:0] mg;
  logic       [9:0]  a0, a1, l0, l1, x0, x1;
  logic       [10:0] m0, m1;
  logic       [31:0] rq[$], r;
  logic       [21:0] mq[$];
  logic       [31:0] seed;
  logic       [15:0] rv[9] = '{16'h1, 16'h0, 16'hff, 16'h28, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  int                mt[5] = '{10, 20, 30, -5, 100};
  int                num_errors, n_tests;
  pwl_top #(.TICK_CYCLES(20)) u_dut (.ref_clk_in(ref_clk), .rst_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .rx_pkt_in(rx),
    .rx_margin_in(mg), .io_pkt_in(io), .io_src_addr_in(src), .analog_in_0_vld_in(v0),
    .analog_in_0_in(a0), .analog_in_1_vld_in(v1), .analog_in_1_in(a1),
    .pulse_out_0_out(p0), .pulse_out_1_out(p1));
  pwl_far_model u_far (.ref_clk_in(ref_clk), .rst_in(rst), .pulse_out_0_out(p0),
    .pulse_out_1_out(p1), .meas_0_out(m0), .meas_1_out(m1), .meas_vld_out(mv));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  function automatic logic [10:0] dexp(input logic [9:0] l);
    dexp = (l == 10'h3ff) ? 11'd1600 : 11'((l * 25) >> 4);
  endfunction
  function automatic logic [10:0] sexp(input int m);
    int s;
    s = (m > 0) ? 107 + ((m * 242) >> 5) : 107 + 4 * m;
    s = (s > 445) ? 445 : (s < 5) ? 5 : s;
    sexp = (s == 445) ? 11'd1600 : 11'((s * 115) >> 5);
  endfunction
  task wrr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rq.push_back({m, e});
    rd <= 1'b0;
  endtask
  task iop(input logic [15:0] s, input logic b0, b1, input logic [9:0] y0, y1);
    @(posedge ref_clk);
    {src, v0, v1, a0, a1, io} <= {s, b0, b1, y0, y1, 1'b1};
    @(posedge ref_clk);
    io <= 1'b0;
  endtask
  task rxp(input int m);
    @(posedge ref_clk);
    mg <= 8'(m);
    rx <= 1'b1;
    @(posedge ref_clk);
    rx <= 1'b0;
  endtask
  task wv;
    do @(posedge ref_clk); while (mv !== 1'b1);
  endtask
  task meas(input logic [10:0] e0, e1);
    repeat (2) wv;
    mq.push_back({e0, e1});
    arm <= 1'b1;
    wv;
    arm <= 1'b0;
  endtask
  task chk_reg(input logic [31:0] x);
    n_tests++;
    if ((rdat & x[31:16]) !== x[15:0]) begin
      num_errors++;
      $display("BAD reg_rdata exp %h got %h", x[15:0], rdat & x[31:16]);
    end
  endtask
  task chk_duty(input logic [21:0] x);
    n_tests++;
    if ({m0, m1} !== x) begin
      num_errors++;
      $display("BAD high_count exp %h got %h", x, {m0, m1});
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Monitor takes the oldest note when a result appears
  always @(posedge ref_clk) begin
    rd_d <= rd;
    if (rd_d) chk_reg(rq.pop_front());
    if (mv && arm) chk_duty(mq.pop_front());
  end
  // Watchdog
  initial begin
    #(40 * 80000);
    num_errors++;
    end_sim;
  end
  // Main sequence
  initial begin
    {rst, wr, rd, rx, io, v0, v1, arm} = 8'h80;
    {addr, wd, src, mg, a0, a1} = '0;
    {num_errors, n_tests} = '0;
    seed = 32'hae3eaf22;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rv[i]) rdc(8'(i * 4), rv[i], 16'hffff);
    meas(11'd0, 11'd0);
    $display("reset test done");
    wrr(8'h00, 16'h2);
    wrr(8'h04, 16'h2);
    wrr(8'h00, 16'h3);
    rdc(8'h00, 16'h2, 16'hffff);
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      l0 = (i == 1) ? 10'h3ff : r[9:0];
      l1 = (i == 2) ? 10'h0 : r[19:10];
      wrr(8'h14, {6'h0, l0});
      wrr(8'h18, {6'h0, l1});
      meas(dexp(l0), dexp(l1));
    end
    $display("duty test done");
    r = $random(seed);
    {sa, x0, x1} = {r[15:0], r[25:16], ~r[25:16]};
    wrr(8'h10, sa);
    iop(~sa, 1'b1, 1'b1, x1, x0);
    rdc(8'h14, {6'h0, l0}, 16'hffff);
    iop(sa, 1'b1, 1'b1, x0, x1);
    rdc(8'h14, {6'h0, x0}, 16'hffff);
    rdc(8'h18, {6'h0, x1}, 16'hffff);
    meas(dexp(x0), dexp(x1));
    wrr(8'h08, 16'h4);
    iop(sa, 1'b1, 1'b0, x0, 10'h0);
    repeat (6) begin
      repeat (50) @(posedge ref_clk);
      iop(sa, 1'b0, 1'b0, 10'h0, 10'h0);
    end
    rdc(8'h1c, 16'h4, 16'h4);
    rdc(8'h14, {6'h0, x0}, 16'hffff);
    repeat (100) @(posedge ref_clk);
    rdc(8'h14, 16'h0, 16'hffff);
    rdc(8'h18, 16'h0, 16'hffff);
    rdc(8'h1c, 16'h0, 16'h7);
    $display("passing test done");
    wrr(8'h00, 16'h1);
    wrr(8'h0c, 16'hff);
    foreach (mt[i]) begin
      rxp(mt[i]);
      meas(sexp(mt[i]), 11'd0);
    end
    wrr(8'h0c, 16'h3);
    rxp(20);
    rdc(8'h1c, 16'h8, 16'h8);
    repeat (100) @(posedge ref_clk);
    rdc(8'h1c, 16'h0, 16'h8);
    meas(11'd0, 11'd0);
    rxp(20);
    rdc(8'h1c, 16'h8, 16'h8);
    wrr(8'h0c, 16'hff);
    rxp(20);
    wrr(8'h00, 16'h0);
    meas(11'd0, 11'd0);
    repeat (3) @(posedge ref_clk);
    $display("strength test done");
    end_sim;
  end
endmodule
